// File: common/bds_pkg.sv
/*
  Constants for the board-device DMA and interrupt steering block.
  Assumes a single core clock domain and plain control ports, no bus.
*/
package bds_pkg;
  localparam int DMA_LINES = 2;
  localparam int IRQ_LINES = 2;
  localparam int DMA_CHANNELS = 8;
  localparam int IRQ_INPUTS = 16;
  localparam int SEL_W = 4;
  // DMA channel 4 is the cascade and may not be steered to
  localparam logic [7:0] DMA_CHAN_LEGAL = 8'hEF;
  // Steerable interrupt inputs: 15,14,12..9,7..3
  localparam logic [15:0] IRQ_INPUT_LEGAL = 16'hDEF8;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic [7:0] DMA_RESET = 8'h00;
  localparam logic [1:0] LINE_RESET = 2'h0;
  localparam logic ACK_IDLE_N = 1'b1;
endpackage : bds_pkg

// File: src/bds_sync.sv
/*
  Two-flop synchroniser, one per bit, for lines arriving from the board.
  Assumes the inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bds_sync #(
  parameter int WIDTH = 2
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } bds_sync_t;

  bds_sync_t state;
  bds_sync_t next_state;

  always_comb begin
    next_state = state;
    next_state.meta = asyncIn;
    next_state.stable = state.meta;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stable;
endmodule : bds_sync
`default_nettype wire

// File: src/bds_steering.sv
/*
  Steers board-device DMA request/acknowledge pairs onto DMA channels
  and board interrupt lines onto interrupt-controller inputs, with ISA
  masking or sharing, and the timer-interrupt output option on line 0.
  Assumes routing ports are static configuration held by software logic
  on core_clk; board and ISA pins are asynchronous and synchronised here.
*/
// Operation
// R1 - Each board DMA request may be joined to DMA channel 0-3 or 5-7.
// R2 - Each board DMA acknowledge follows the acknowledge of its routed channel.
// R3 - Each DMA pair has its own independent routing control.
// R4 - Each board DMA signal may instead serve as a steerable interrupt source.
// R5 - Each board interrupt line may go to input 15,14,12-9 or 7-3.
// R6 - Each board interrupt line has its own route control selecting the input.
// R7 - A steered line masks the matching ISA pin unless sharing is enabled.
// R8 - Board device shares with a PCI line only as active-high level.
// R9 - Software enables ISA sharing only when both devices are active-high level.
// R10 - Line 0 is interrupt input or timer output per its enable bit.
// R11 - As output, line 0 carries the internal timer interrupt outward.
// R12 - An unrouted line is ignored and its acknowledge stays high.
`timescale 1ns/1ps
`default_nettype none
module bds_steering #(
  parameter int DMA_LINES = bds_pkg::DMA_LINES,
  parameter int IRQ_LINES = bds_pkg::IRQ_LINES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // Board-device pins
  input wire logic [DMA_LINES-1:0] board_dma_req,
  output logic [DMA_LINES-1:0] board_dma_ack_n,
  input wire logic [IRQ_LINES-1:0] board_irq_in,
  output logic board_irq0_or_timer_out,
  output logic board_irq0_oe,
  // Per-line DMA routing
  input wire logic [DMA_LINES-1:0] dmaRouteEnable,
  input wire logic [DMA_LINES*bds_pkg::SEL_W-1:0] dmaRouteChannel,
  input wire logic [DMA_LINES-1:0] dmaAsIrqEnable,
  input wire logic [DMA_LINES*bds_pkg::SEL_W-1:0] dmaIrqSelect,
  input wire logic [DMA_LINES-1:0] dmaIrqShare,
  // Per-line interrupt routing
  input wire logic [IRQ_LINES-1:0] irqRouteEnable,
  input wire logic [IRQ_LINES*bds_pkg::SEL_W-1:0] irqRouteSelect,
  input wire logic [IRQ_LINES-1:0] irqShare,
  input wire logic timer_irq_output_enable,
  // Internal side
  input wire logic [bds_pkg::DMA_CHANNELS-1:0] dmaChanAck,
  output logic [bds_pkg::DMA_CHANNELS-1:0] dmaChanReq,
  input wire logic timerIrq,
  input wire logic [bds_pkg::IRQ_INPUTS-1:0] isaIrqPins,
  output logic [bds_pkg::IRQ_INPUTS-1:0] picIrqIn
);

  // All outputs except the pin enable are registered, so a routing
  // change shows one edge later on every output at once.
  typedef struct packed {
    logic [DMA_LINES-1:0] ackN;
    logic [bds_pkg::DMA_CHANNELS-1:0] chanReq;
    logic [bds_pkg::IRQ_INPUTS-1:0] picIrq;
    logic timerOut;
  } bds_state_t;

  bds_state_t state;
  bds_state_t next_state;
  logic [DMA_LINES-1:0] dmaReqSync;
  logic [IRQ_LINES-1:0] irqSync;
  logic [bds_pkg::IRQ_INPUTS-1:0] isaSync;

  // Board and ISA pins come from outside the core clock domain
  bds_sync #(.WIDTH(DMA_LINES)) uDmaSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(board_dma_req),
    .syncOut(dmaReqSync)
  );
  bds_sync #(.WIDTH(IRQ_LINES)) uIrqSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(board_irq_in),
    .syncOut(irqSync)
  );
  bds_sync #(.WIDTH(bds_pkg::IRQ_INPUTS)) uIsaSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn(isaIrqPins),
    .syncOut(isaSync)
  );


  // Per-line routing decode, independent per line.
  // An illegal select is treated as no route at all: a stray value
  // must never reach the cascade channel or a reserved input.
  logic [DMA_LINES-1:0] dmaLegal;
  logic [DMA_LINES-1:0] dmaIrqLegal;
  logic [IRQ_LINES-1:0] irqLegal;
  logic [IRQ_LINES-1:0] irqActiveIn;

  genvar g;
  generate
    for (g = 0; g < DMA_LINES; g++) begin : gDma
      logic [bds_pkg::SEL_W-1:0] chan;
      logic [bds_pkg::SEL_W-1:0] isel;
      assign chan = dmaRouteChannel[g*bds_pkg::SEL_W +: bds_pkg::SEL_W]; // R3
      assign isel = dmaIrqSelect[g*bds_pkg::SEL_W +: bds_pkg::SEL_W];
      // Channel select's top bit is ignored; 4 is the cascade
      assign dmaLegal[g] = dmaRouteEnable[g] && !dmaAsIrqEnable[g]
        && bds_pkg::DMA_CHAN_LEGAL[chan[2:0]]; // R1
      assign dmaIrqLegal[g] = dmaAsIrqEnable[g]
        && bds_pkg::IRQ_INPUT_LEGAL[isel]; // R4
    end
    for (g = 0; g < IRQ_LINES; g++) begin : gIrq
      logic [bds_pkg::SEL_W-1:0] isel;
      assign isel = irqRouteSelect[g*bds_pkg::SEL_W +: bds_pkg::SEL_W]; // R6
      assign irqLegal[g] = irqRouteEnable[g] && bds_pkg::IRQ_INPUT_LEGAL[isel]; // R5
      // Line 0 stops being an input while it drives the timer out
      assign irqActiveIn[g] = irqLegal[g]
        && !(g == 0 && timer_irq_output_enable); // R10
    end
  endgenerate

  always_comb begin
    logic [bds_pkg::IRQ_INPUTS-1:0] steered;
    logic [bds_pkg::IRQ_INPUTS-1:0] masked;
    logic [bds_pkg::SEL_W-1:0] sel;
    steered = '0;
    masked = '0;
    sel = '0;
    next_state = state;
    next_state.chanReq = bds_pkg::DMA_RESET;
    next_state.ackN = {DMA_LINES{bds_pkg::ACK_IDLE_N}}; // R12

    // DMA pairs; two pairs on one channel share its acknowledge,
    // which software must avoid since both devices would be granted
    for (int i = 0; i < DMA_LINES; i++) begin
      sel = dmaRouteChannel[i*bds_pkg::SEL_W +: bds_pkg::SEL_W];
      if (dmaLegal[i]) begin
        next_state.chanReq[sel[2:0]] = next_state.chanReq[sel[2:0]] | dmaReqSync[i]; // R1
        next_state.ackN[i] = !dmaChanAck[sel[2:0]]; // R2
      end
    end

    // Pair requests used as interrupt sources instead
    for (int i = 0; i < DMA_LINES; i++) begin
      sel = dmaIrqSelect[i*bds_pkg::SEL_W +: bds_pkg::SEL_W];
      if (dmaIrqLegal[i]) begin
        steered[sel] = steered[sel] | dmaReqSync[i]; // R4
        if (!dmaIrqShare[i]) begin
          masked[sel] = 1'b1; // R7
        end
      end
    end

    // Board interrupt lines
    for (int i = 0; i < IRQ_LINES; i++) begin
      sel = irqRouteSelect[i*bds_pkg::SEL_W +: bds_pkg::SEL_W];
      if (irqActiveIn[i]) begin
        // Shared use is only sound for active-high level sources
        steered[sel] = steered[sel] | irqSync[i]; // R5 R8 R9
        if (!irqShare[i]) begin
          masked[sel] = 1'b1; // R7
        end
      end
    end

    // Mask holds even while the board line is idle, so a masked ISA
    // source stays silent as long as the route stands.
    // Any unshared source on an input masks it, whatever the others say;
    // the safer choice when two routes disagree.
    next_state.picIrq = (isaSync & ~masked) | steered; // R7

    // Timer copy is forced low while the pin serves as an input
    next_state.timerOut = timer_irq_output_enable & timerIrq; // R11
  end

  // Acks leave reset high so no board device sees a false grant

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state.ackN <= {DMA_LINES{bds_pkg::ACK_IDLE_N}};
      state.chanReq <= bds_pkg::DMA_RESET;
      state.picIrq <= bds_pkg::IRQ_RESET;
      state.timerOut <= 1'b0;
    end else begin
      state <= next_state;
    end
  end


  // Registered outputs
  assign board_dma_ack_n = state.ackN;
  assign dmaChanReq = state.chanReq;
  assign picIrqIn = state.picIrq;
  assign board_irq0_or_timer_out = state.timerOut; // R11

  // Enable stays combinational: the pin turns around on the same edge
  // as the setting, and the driven value is low until the timer copy
  // has been registered, so no glitch of old input data goes out.
  assign board_irq0_oe = timer_irq_output_enable; // R10
endmodule : bds_steering
`default_nettype wire

// File: tb/bds_steering_props.sv
/* Port assertions for bds_steering. Assumes bind by port name. */
`timescale 1ns/1ps
`default_nettype none
module bds_steering_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] board_dma_req,
  input wire logic [1:0] board_dma_ack_n,
  input wire logic [1:0] board_irq_in,
  input wire logic board_irq0_or_timer_out,
  input wire logic board_irq0_oe,
  input wire logic [1:0] dmaRouteEnable,
  input wire logic [7:0] dmaRouteChannel,
  input wire logic [1:0] dmaAsIrqEnable,
  input wire logic [1:0] irqRouteEnable,
  input wire logic [7:0] irqRouteSelect,
  input wire logic [1:0] irqShare,
  input wire logic timer_irq_output_enable,
  input wire logic [7:0] dmaChanAck,
  input wire logic [7:0] dmaChanReq,
  input wire logic timerIrq,
  input wire logic [15:0] picIrqIn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic dmaOn = dmaRouteEnable[0] && !dmaAsIrqEnable[0] && dmaRouteChannel[2:0] != 3'h4;
  ack_idle_a: assert property (!dmaRouteEnable[0] |=> board_dma_ack_n[0]) else $error("ack");
  ack_follow_a: assert property (dmaOn && dmaChanAck[dmaRouteChannel[2:0]]
    |=> !board_dma_ack_n[0]) else $error("ack pass");
  no_cascade_a: assert property (!dmaChanReq[4]) else $error("ch4");
  req_path_a: assert property ((dmaOn && board_dma_req[0]) [*3]
    |=> dmaChanReq[$past(dmaRouteChannel[2:0])]) else $error("req");
  timer_out_a: assert property (timer_irq_output_enable && timerIrq
    |=> board_irq0_or_timer_out) else $error("timer");
  timer_oe_a: assert property (board_irq0_oe == timer_irq_output_enable) else $error("oe");
  irq_steer_a: assert property ((irqRouteEnable[1] && irqRouteSelect[7:4] == 4'hE
    && board_irq_in[1]) [*3] |=> picIrqIn[14]) else $error("steer");
  isa_mask_a: assert property ((irqRouteEnable == 2'h2 && !irqShare[1]
    && irqRouteSelect[7:4] == 4'hA && dmaAsIrqEnable == 2'h0 && !board_irq_in[1]) [*3]
    |=> !picIrqIn[10]) else $error("mask");
  cover property (!board_dma_ack_n[0]);
  cover property (board_irq0_or_timer_out);
  cover property (picIrqIn[14]);
endmodule : bds_steering_props
bind bds_steering bds_steering_props props (.*);
`default_nettype wire

// File: tb/bds_board_dev.sv
/* Board peripheral model. Assumes the bench sets what it wants. */
`timescale 1ns/1ps
`default_nettype none
module bds_board_dev (
  input wire logic core_clk,
  input wire logic [1:0] wantDma,
  input wire logic [1:0] wantIrq,
  input wire logic [1:0] board_dma_ack_n,
  output logic [1:0] board_dma_req = 2'h0,
  output logic [1:0] board_irq_in = 2'h0
);
  always @(posedge core_clk) begin
    // Drops request once served, as a real requester
    board_dma_req <= wantDma & board_dma_ack_n;
    board_irq_in <= wantIrq;
  end
endmodule : bds_board_dev
`default_nettype wire

// File: tb/test_bds_steering.sv
/* Bench for bds_steering. Assumes board model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_bds_steering;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic timer_irq_output_enable = 1'h0, timerIrq = 1'h0, board_irq0_or_timer_out, board_irq0_oe;
  logic [1:0] board_dma_req, board_dma_ack_n, board_irq_in, wantDma = 2'h0, wantIrq = 2'h0;
  logic [1:0] dmaRouteEnable = 2'h0, dmaAsIrqEnable = 2'h0, dmaIrqShare = 2'h0;
  logic [1:0] irqRouteEnable = 2'h0, irqShare = 2'h0;
  logic [7:0] dmaRouteChannel = 8'h0, dmaIrqSelect = 8'h0, irqRouteSelect = 8'h0;
  logic [7:0] dmaChanAck = 8'h0, dmaChanReq;
  logic [15:0] isaIrqPins = 16'h0, picIrqIn;
  logic [7:0] dmaRow [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h20, 8'h40, 8'h80};
  int mismatches = 0, checkCount = 0;
  always #5 core_clk = ~core_clk;
  bds_steering uut (.*);
  bds_board_dev board (.*);
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task look(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : look
  task give_verdict;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    look(8);
    chk("ack rst", board_dma_ack_n, 16'h3);
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    dmaRouteEnable <= 2'h1;
    wantDma <= 2'h1;
    for (int i = 0; i < 8; i++) begin
      dmaRouteChannel <= 8'(i);
      look(6);
      chk("req", dmaChanReq, dmaRow[i]);
      @(posedge core_clk);
      dmaChanAck <= dmaRow[i];
      look(1);
      chk("ack", board_dma_ack_n, {1'b1, dmaRow[i] == 8'h00});
      @(posedge core_clk);
      dmaChanAck <= 8'h00;
    end
    dmaRouteEnable <= 2'h0;
    dmaChanAck <= 8'h80;
    look(3);
    chk("ack off", board_dma_ack_n, 16'h3);
    chk("req off", dmaChanReq, 16'h0);
    @(posedge core_clk);
    dmaChanAck <= 8'h00;
    dmaAsIrqEnable <= 2'h1;
    dmaIrqSelect <= 8'h09;
    look(4);
    chk("dma irq", picIrqIn, 16'h0200);
    @(posedge core_clk);
    dmaAsIrqEnable <= 2'h0;
    irqRouteEnable <= 2'h2;
    wantIrq <= 2'h2;
    for (int s = 0; s < 16; s++) begin
      irqRouteSelect <= {s[3:0], 4'h0};
      look(4);
      chk("steer", picIrqIn, bds_pkg::IRQ_INPUT_LEGAL & (16'h1 << s));
      @(posedge core_clk);
    end
    wantIrq <= 2'h0;
    irqRouteSelect <= 8'hA0;
    isaIrqPins <= 16'h0400;
    look(4);
    chk("masked", picIrqIn, 16'h0);
    @(posedge core_clk);
    irqShare <= 2'h2;
    look(4);
    chk("shared", picIrqIn, 16'h0400);
    @(posedge core_clk);
    irqRouteEnable <= 2'h1;
    irqRouteSelect <= 8'h03;
    wantIrq <= 2'h1;
    isaIrqPins <= 16'h0;
    timer_irq_output_enable <= 1'h1;
    timerIrq <= 1'h1;
    look(4);
    chk("timer", {board_irq0_oe, board_irq0_or_timer_out}, 16'h3);
    chk("line0 off", picIrqIn, 16'h0);
    @(posedge core_clk);
    timer_irq_output_enable <= 1'h0;
    look(4);
    chk("line0 in", picIrqIn, 16'h0008);
    give_verdict();
  end
endmodule : test_bds_steering
`default_nettype wire
